// ===== shared/ddrb_link_if.sv
// ddrb_link_if: the pins between memory controller and burst sram
// assumes: the bench drives termination_range_select (1 when left floating)
`timescale 1ns/1ps
interface ddrb_link_if #(parameter int DW = 36, parameter int AW = 4);
    logic k; // positive input clock
    logic k_n; // complementary input clock
    logic load_strobe_n; // low marks a new transaction
    logic rw_sel; // high read, low write
    logic [AW-1:0] addr; // burst address
    logic [DW-1:0] ctl_dq_o; // controller data out
    logic ctl_dq_oe_n; // controller drives when low
    logic [DW-1:0] dev_dq_o; // device data out
    logic dev_dq_oe_n; // device drives when low
    logic [DW-1:0] dq; // resolved data wire
    logic echo_clock; // echo clock, true
    logic echo_clock_n; // echo clock, complement
    logic output_valid_flag; // read data on the bus
    logic pll_disable_n; // low switches the loop off
    logic termination_range_select; // strap, high range when high
    // resolve the shared data wire; an idle bus reads zero
    assign dq = !ctl_dq_oe_n ? ctl_dq_o : (!dev_dq_oe_n ? dev_dq_o : '0);
    modport ctl (
        output k, k_n, load_strobe_n, rw_sel, addr, ctl_dq_o, ctl_dq_oe_n, pll_disable_n,
        input dq, echo_clock, echo_clock_n, output_valid_flag
    );
    modport dev (
        input k, k_n, load_strobe_n, rw_sel, addr, dq, pll_disable_n, termination_range_select,
        output dev_dq_o, dev_dq_oe_n, echo_clock, echo_clock_n, output_valid_flag
    );
endinterface : ddrb_link_if

// ===== shared/ddrb_map.svh
// ddrb_map.svh: widths, fifo depth, field positions and timing counts of the burst sram link
// assumes: included by bare name wherever the link constants are needed
`ifndef DDRB_MAP_SVH
`define DDRB_MAP_SVH
// link widths
`define DATA_W 36
`define ADDR_W 4
// command fifo depth in words
`define FIFO_DEPTH 16
// system clock period in ns (250 MHz)
`define SYS_PERIOD_NS 4
// link clock half period in system cycles (80 ns period)
`define K_HALF_CYC 10
// highest link clock rate with the loop switched off
`define PLL_DISABLE_N_FMAX_MHZ 167
// least half period in cycles at that rate, rounded up
`define PLL_DISABLE_N_MIN_HALF ((1000 + 2 * `PLL_DISABLE_N_FMAX_MHZ * `SYS_PERIOD_NS - 1) / (2 * `PLL_DISABLE_N_FMAX_MHZ * `SYS_PERIOD_NS))
// read latency in link half cycles: loop on, loop off
`define RD_LAT_HALF_PLL 5
`define RD_LAT_HALF_OFF 2
// idle link cycles between a read and a following write
`define RD2WR_NOPS 3
// bit positions in the device's synchronised control vector
`define IN_K 0
`define IN_KN 1
`define IN_LD 2
`define IN_RW 3
`define IN_PLL 4
`define IN_TERM 5
`define IN_CTL_W 6
`endif

// ===== shared/ddrb_pkg.sv
// ddrb_pkg: types shared by both ends of the burst sram link
// assumes: constants come from ddrb_map.svh
package ddrb_pkg;
    // command placed on the link for one link clock cycle
    typedef enum logic [2:0] {
        CMD_NOP = 3'h1,
        CMD_READ = 3'h2,
        CMD_WRITE = 3'h4
    } link_cmd_e;
endpackage : ddrb_pkg

// ===== testbench/ddrb_burst_sram_control_clocking_tb.sv
// bench: controller and sram joined by the link, driven from the user command port
// assumes: design files and the link interface compiled first
`timescale 1ns/1ps
module ddrb_burst_sram_control_clocking_tb;
    logic sys_clk;
    logic rstn;
    logic cmd_valid;
    logic cmd_ready;
    logic cmd_write;
    logic [3:0] cmd_addr;
    logic [71:0] cmd_wdata;
    logic pll_off;
    logic rd_valid;
    logic [71:0] rd_data;
    logic term_sel; // strap level, 1 stands for floating
    logic term_high;
    logic pll_act;
    logic saw_full; // set when the fifo refused a command
    int errors;
    int n_compared;
    int cycles;
    ddrb_link_if #(.DW(36), .AW(4)) link ();
    assign link.termination_range_select = term_sel;
    ddrb_sram_ctl #(.K_HALF(10)) ddrb_sram_ctl_i (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .pll_off(pll_off), .rd_valid(rd_valid), .rd_data(rd_data), .link(link.ctl));
    ddrb_sram_dev ddrb_sram_dev_i (.sys_clk(sys_clk), .rstn(rstn), .link(link.dev),
        .term_range_high(term_high), .pll_active(pll_act));
    ddrb_link_checker #(.K_HALF(10)) ddrb_link_checker_i (.sys_clk(sys_clk), .rstn(rstn), .k(link.k),
        .k_n(link.k_n), .load_strobe_n(link.load_strobe_n), .rw_sel(link.rw_sel),
        .ctl_dq_oe_n(link.ctl_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n), .echo_clock(link.echo_clock),
        .echo_clock_n(link.echo_clock_n), .output_valid_flag(link.output_valid_flag),
        .pll_disable_n(link.pll_disable_n));
    // 250 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard, well above the longest expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            finish_test();
        end
    end
    // distinct halves per address and salt so swapped words show
    function automatic logic [71:0] pat(input logic [3:0] a, input logic [7:0] s);
        return {4'h3, 20'h0, ~s, a, 4'hC, 20'h0, s, a};
    endfunction : pat
    task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check
    // synchronous reset held for 12 cycles
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
    endtask : do_reset
    // offer one command; valid stays up so calls may run back to back
    task automatic push(input logic w, input logic [3:0] a, input logic [71:0] d);
        int n;
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(negedge sys_clk);
        for (n = 0; cmd_ready !== 1'b1 && n < 2000; n++) begin
            saw_full = 1'b1;
            @(negedge sys_clk);
        end
        check(72'(cmd_ready), 72'h1, "command taken");
        @(posedge sys_clk);
    endtask : push
    // one read, then wait for its pair under a bound
    task automatic read_chk(input logic [3:0] a, input logic [71:0] exp);
        int n;
        push(1'b0, a, 72'h0);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        for (n = 0; rd_valid !== 1'b1 && n < 2000; n++) @(negedge sys_clk);
        check(72'(rd_valid), 72'h1, "read pair returned");
        check(rd_data, exp, "read data");
        // back on a rising edge, so the next command is not taken twice
        @(posedge sys_clk);
    endtask : read_chk
    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    // main sequence
    initial begin
        int i;
        int e_cnt;
        logic e_prev;
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 4'h0;
        cmd_wdata = 72'h0;
        pll_off = 1'b0;
        term_sel = 1'b1;
        saw_full = 1'b0;
        errors = 0;
        n_compared = 0;
        do_reset();
        // idle link: echo must still run at the k rate
        e_cnt = 0;
        e_prev = link.echo_clock;
        repeat (400) begin
            @(negedge sys_clk);
            if (link.echo_clock && !e_prev) e_cnt++;
            e_prev = link.echo_clock;
        end
        check(72'(e_cnt >= 19 && e_cnt <= 21), 72'h1, "echo rate");
        check(72'(term_high), 72'h1, "floating strap");
        check(72'(pll_act), 72'h1, "loop on");
        // commands are driven from a rising edge
        @(posedge sys_clk);
        // back-to-back writes fill the fifo until it refuses, last four overwrite
        for (i = 0; i < 20; i++) push(1'b1, i[3:0], pat(i[3:0], (i < 16) ? 8'h11 : 8'h22));
        cmd_valid <= 1'b0;
        check(72'(saw_full), 72'h1, "fifo refused");
        for (i = 0; i < 16; i++) read_chk(i[3:0], pat(i[3:0], (i < 4) ? 8'h22 : 8'h11));
        // loop off: short latency mode
        pll_off <= 1'b1;
        repeat (100) @(posedge sys_clk);
        check(72'(link.pll_disable_n), 72'h0, "pll pin");
        check(72'(pll_act), 72'h0, "loop off");
        push(1'b1, 4'h5, pat(4'h5, 8'h33));
        push(1'b1, 4'h6, pat(4'h6, 8'h44));
        read_chk(4'h6, pat(4'h6, 8'h44));
        read_chk(4'h5, pat(4'h5, 8'h33));
        // second reset with the strap low
        term_sel <= 1'b0;
        pll_off <= 1'b0;
        do_reset();
        repeat (8) @(posedge sys_clk);
        check(72'(term_high), 72'h0, "low strap");
        push(1'b1, 4'hF, pat(4'hF, 8'h55));
        read_chk(4'hF, pat(4'hF, 8'h55));
        finish_test();
    end
endmodule : ddrb_burst_sram_control_clocking_tb

// ===== testbench/ddrb_link_checker.sv
// ddrb_link_checker: pin-level checks on the link between controller and sram
// assumes: instantiated beside the link interface, K_HALF matching the controller
`timescale 1ns/1ps
module ddrb_link_checker #(
    parameter int K_HALF = 10
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic k,
    input wire logic k_n,
    input wire logic load_strobe_n,
    input wire logic rw_sel,
    input wire logic ctl_dq_oe_n,
    input wire logic dev_dq_oe_n,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic output_valid_flag,
    input wire logic pll_disable_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [15:0] low_cnt; // cycles the load strobe has been low
    // count load-low cycles; a strobe cut short leaves a partial link cycle
    always_ff @(posedge sys_clk) begin
        if (!rstn || load_strobe_n) begin
            low_cnt <= 16'h0;
        end else begin
            low_cnt <= low_cnt + 16'h1;
        end
    end
    valid_on_bus_a: assert property (output_valid_flag |-> !dev_dq_oe_n)
        else $error("valid flag high while device is off the bus");
    idle_flag_low_a: assert property (dev_dq_oe_n |-> !output_valid_flag)
        else $error("valid flag high with no read word driven");
    flag_with_echo_a: assert property ($changed(output_valid_flag) |-> $changed(echo_clock))
        else $error("valid flag moved without an echo edge");
    echo_on_k_a: assert property ($rose(k) |-> ##[1:5] echo_clock)
        else $error("echo did not follow k rise");
    echo_on_kn_a: assert property ($rose(k_n) |-> ##[1:5] !echo_clock)
        else $error("echo did not follow k_n rise");
    echo_pair_a: assert property (echo_clock_n == !echo_clock)
        else $error("echo pair not complementary");
    k_pair_a: assert property (k_n == !k)
        else $error("input clocks not complementary");
    no_contention_a: assert property (!(!ctl_dq_oe_n && !dev_dq_oe_n))
        else $error("both ends drive the data bus");
    load_whole_a: assert property ($rose(load_strobe_n) |-> (low_cnt % (2 * K_HALF)) == 0)
        else $error("load strobe not held whole link cycles");
    read_lat_pll_a: assert property ($rose(k) && !load_strobe_n && rw_sel && pll_disable_n
        |-> ##[44:58] output_valid_flag)
        else $error("read data late with loop on");
    read_lat_off_a: assert property ($rose(k) && !load_strobe_n && rw_sel && !pll_disable_n
        |-> ##[16:28] output_valid_flag)
        else $error("read data late with loop off");
    cover property ($rose(k) && !load_strobe_n && rw_sel && pll_disable_n);
    cover property ($rose(k) && !load_strobe_n && rw_sel && !pll_disable_n);
    cover property ($rose(k) && !load_strobe_n && !rw_sel);
endmodule : ddrb_link_checker

// ===== verilog/ddrb_sram_ctl.sv
// ddrb_sram_ctl: the memory controller end, with its command fifo
// assumes: user side is on sys_clk; echo, flag and data from the device are synchronised here
`timescale 1ns/1ps
`include "ddrb_map.svh"
// plain fifo in flip-flops; depth a power of two
module ddrb_fifo #(
    parameter int W = 8,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem; // storage
        logic [PW-1:0] wp; // write index
        logic [PW-1:0] rp; // read index
        logic [PW:0] cnt; // words held
        logic not_full; // registered ready
        logic not_empty; // registered valid
    } fifo_s;
    fifo_s s; // registered state
    fifo_s next_s; // next state
    logic push; // word taken in
    logic pop; // word handed out

    assign in_ready = s.not_full;
    assign out_valid = s.not_empty;
    assign out_data = s.mem[s.rp];

    // pointers and honest flags from the next count
    always_comb begin
        next_s = s;
        push = in_valid & s.not_full;
        pop = out_ready & s.not_empty;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = PW'(s.wp + 1'b1);
        end
        if (pop) begin
            next_s.rp = PW'(s.rp + 1'b1);
        end
        next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
        next_s.not_full = next_s.cnt != (PW+1)'(DEPTH);
        next_s.not_empty = next_s.cnt != '0;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s <= '0;
            s.not_full <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule : ddrb_fifo

module ddrb_sram_ctl #(
    parameter int DW = `DATA_W,
    parameter int AW = `ADDR_W,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int K_HALF = `K_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [2*DW-1:0] cmd_wdata,
    input wire logic pll_off,
    output logic rd_valid,
    output logic [2*DW-1:0] rd_data,
    ddrb_link_if.ctl link
);
    localparam int FW = 1 + AW + 2 * DW;
    // loop off: never faster than the mode allows
    localparam int HALF_OFF = K_HALF > `PLL_DISABLE_N_MIN_HALF ? K_HALF : `PLL_DISABLE_N_MIN_HALF;

    // all state of the controller
    typedef struct packed {
        logic [15:0] cnt; // divider count
        logic k; // link clock
        logic kn; // its complement
        logic ld_n; // load strobe
        logic rw; // read/write select
        logic [AW-1:0] addr; // address on the link
        logic [DW-1:0] dq_o; // write data out
        logic dq_oe_n; // low while driving
        logic pll_n; // loop enable pin
        logic wr_a; // write issued, first word due
        logic wr_b; // second word due
        logic [2*DW-1:0] wcmd; // data of the issued write
        logic [2*DW-1:0] wdat; // data being sent
        logic [3:0] gap; // idle cycles still owed after a read
        logic [1:0] meta_in; // first sync stage: flag, echo
        logic [1:0] sync_in; // second sync stage
        logic [DW-1:0] meta_dq; // first sync stage, data
        logic [DW-1:0] sync_dq; // second sync stage, data
        logic echo_prev; // last echo level
        logic have_w0; // first read word held
        logic [DW-1:0] w0; // that word
        logic rd_valid; // pair complete
        logic [2*DW-1:0] rd_data; // returned pair
    } ctl_s;

    ctl_s s; // registered state
    ctl_s next_s; // next state
    logic [FW-1:0] head; // oldest queued command
    logic head_ok; // fifo holds one
    logic pop; // take it this cycle
    logic mid_lo; // middle of the k low half
    logic mid_hi; // middle of the k high half
    logic [15:0] half; // half period in use
    ddrb_pkg::link_cmd_e sel; // command chosen now

    // the queue stalls the user once it holds DEPTH commands
    ddrb_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_write, cmd_addr, cmd_wdata}),
        .out_valid(head_ok),
        .out_data(head),
        .out_ready(pop)
    );

    // pins and user outputs straight from the state
    assign link.k = s.k;
    assign link.k_n = s.kn;
    assign link.load_strobe_n = s.ld_n;
    assign link.rw_sel = s.rw;
    assign link.addr = s.addr;
    assign link.ctl_dq_o = s.dq_o;
    assign link.ctl_dq_oe_n = s.dq_oe_n;
    assign link.pll_disable_n = s.pll_n;
    assign rd_valid = s.rd_valid;
    assign rd_data = s.rd_data;

    // controls change mid-half so they are steady at each clock edge
    always_comb begin
        half = s.pll_n ? 16'(K_HALF) : 16'(HALF_OFF);
        mid_lo = ~s.k & (s.cnt == 16'(K_HALF / 2));
        mid_hi = s.k & (s.cnt == 16'(K_HALF / 2));
        // a write waits until the read turnaround is paid
        pop = mid_lo & head_ok & (~head[FW-1] | (s.gap == 4'h0));
        sel = ddrb_pkg::CMD_NOP;
        if (pop) begin
            sel = head[FW-1] ? ddrb_pkg::CMD_WRITE : ddrb_pkg::CMD_READ;
        end
    end

    // next state: divider, command issue, write data, read capture
    always_comb begin
        next_s = s;
        next_s.pll_n = ~pll_off;
        // divider makes k and k_n
        if (s.cnt >= half - 16'h1) begin
            next_s.cnt = 16'h0;
            next_s.k = ~s.k;
            next_s.kn = s.k;
        end else begin
            next_s.cnt = s.cnt + 16'h1;
        end

        // ahead of a k rise: write word 0, then a new command
        if (mid_lo) begin
            if (s.wr_a) begin
                next_s.dq_o = s.wcmd[DW-1:0]; // first word for this k rise
                next_s.dq_oe_n = 1'b0;
                next_s.wdat = s.wcmd;
                next_s.wr_b = 1'b1;
            end else begin
                next_s.dq_oe_n = 1'b1;
            end
            next_s.wr_a = 1'b0;
            case (sel)
                ddrb_pkg::CMD_READ: begin
                    next_s.ld_n = 1'b0; // load low, select high
                    next_s.rw = 1'b1;
                    next_s.addr = head[FW-2 -: AW];
                    next_s.gap = 4'(`RD2WR_NOPS);
                end
                ddrb_pkg::CMD_WRITE: begin
                    next_s.ld_n = 1'b0; // load low, select low
                    next_s.rw = 1'b0;
                    next_s.addr = head[FW-2 -: AW];
                    next_s.wcmd = head[2*DW-1:0];
                    next_s.wr_a = 1'b1;
                end
                default: begin
                    // idle cycle also pays off the turnaround
                    next_s.ld_n = 1'b1;
                    if (s.gap != 4'h0) begin
                        next_s.gap = s.gap - 4'h1;
                    end
                end
            endcase
        end

        // ahead of a k_n rise: second write word
        if (mid_hi) begin
            if (s.wr_b) begin
                next_s.dq_o = s.wdat[2*DW-1:DW];
                next_s.dq_oe_n = 1'b0;
                next_s.wr_b = 1'b0;
            end else begin
                next_s.dq_oe_n = 1'b1;
            end
        end

        // read side: two flops, then pair words on echo edges with the flag high
        next_s.meta_in = {link.output_valid_flag, link.echo_clock};
        next_s.sync_in = s.meta_in;
        next_s.meta_dq = link.dq;
        next_s.sync_dq = s.meta_dq;
        next_s.echo_prev = s.sync_in[0];
        next_s.rd_valid = 1'b0;
        if ((s.sync_in[0] != s.echo_prev) && s.sync_in[1]) begin
            if (!s.have_w0) begin
                next_s.w0 = s.sync_dq;
                next_s.have_w0 = 1'b1;
            end else begin
                next_s.rd_data = {s.sync_dq, s.w0}; // burst of two
                next_s.rd_valid = 1'b1;
                next_s.have_w0 = 1'b0;
            end
        end
    end

    // state register; link idle and released in reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s <= '0;
            s.kn <= 1'b1;
            s.ld_n <= 1'b1;
            s.dq_oe_n <= 1'b1;
            s.pll_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule : ddrb_sram_ctl

// ===== verilog/ddrb_sram_dev.sv
// ddrb_sram_dev: the burst sram end of the link, modelled on the system clock
// assumes: k, k_n and all link inputs come from another domain and are synchronised here;
// the link half period is at least four system cycles
`timescale 1ns/1ps
`include "ddrb_map.svh"
module ddrb_sram_dev #(
    parameter int DW = `DATA_W,
    parameter int AW = `ADDR_W,
    parameter int DEPTH = 1 << `ADDR_W
) (
    input wire logic sys_clk,
    input wire logic rstn,
    ddrb_link_if.dev link,
    output logic term_range_high,
    output logic pll_active
);
    // read pipeline length: longest latency plus the second word
    localparam int PIPE = `RD_LAT_HALF_PLL + 2;

    // all state of the device
    typedef struct packed {
        logic [`IN_CTL_W-1:0] meta_ctl; // first sync stage, controls
        logic [`IN_CTL_W-1:0] sync_ctl; // second sync stage, controls
        logic [AW-1:0] meta_addr; // first sync stage, address
        logic [AW-1:0] sync_addr; // second sync stage, address
        logic [DW-1:0] meta_dq; // first sync stage, data
        logic [DW-1:0] sync_dq; // second sync stage, data
        logic k_prev; // last k level, for edges
        logic kn_prev; // last k_n level, for edges
        logic [PIPE-1:0] rd_pipe; // pending reads by half cycle
        logic [PIPE-1:0][AW-1:0] rd_addr; // their addresses
        logic wr_cmd; // write taken, first word next
        logic [AW-1:0] wr_cmd_addr; // its address
        logic wr_w1; // second write word due
        logic [AW-1:0] wr_dat_addr; // address of that word
        logic [DEPTH-1:0][1:0][DW-1:0] mem; // storage, two words a line
        logic [DW-1:0] dq_o; // data on the bus
        logic dq_oe_n; // low while driving
        logic echo; // echo clock, true
        logic echo_n; // echo clock, complement
        logic valid; // output valid flag
        logic [1:0] init_cnt; // waits out the synchroniser
        logic init_done; // strap has been caught
        logic term_high; // latched termination range
        logic pll_on; // loop mode, sampled on k rise
    } dev_s;

    dev_s s; // registered state
    dev_s next_s; // next state
    logic k_rise; // k rose this cycle
    logic kn_rise; // k_n rose this cycle
    logic rd_new; // read taken on this k rise
    int lat; // read latency in half cycles

    // outputs come straight from the state
    assign link.dev_dq_o = s.dq_o;
    assign link.dev_dq_oe_n = s.dq_oe_n;
    assign link.echo_clock = s.echo;
    assign link.echo_clock_n = s.echo_n;
    assign link.output_valid_flag = s.valid;
    assign term_range_high = s.term_high;
    assign pll_active = s.pll_on;

    // next state: sync, edge finding, read pipe, writes, strap
    always_comb begin
        next_s = s;
        // two flops on every pin; only the second stage is read
        next_s.meta_ctl = {link.termination_range_select, link.pll_disable_n, link.rw_sel,
                           link.load_strobe_n, link.k_n, link.k};
        next_s.sync_ctl = s.meta_ctl;
        next_s.meta_addr = link.addr;
        next_s.sync_addr = s.meta_addr;
        next_s.meta_dq = link.dq;
        next_s.sync_dq = s.meta_dq;
        // edges of the two input clocks
        k_rise = s.sync_ctl[`IN_K] & ~s.k_prev;
        kn_rise = s.sync_ctl[`IN_KN] & ~s.kn_prev;
        next_s.k_prev = s.sync_ctl[`IN_K];
        next_s.kn_prev = s.sync_ctl[`IN_KN];
        // load low with select high is a read
        rd_new = k_rise & ~s.sync_ctl[`IN_LD] & s.sync_ctl[`IN_RW];
        // latency follows the loop mode
        lat = s.pll_on ? `RD_LAT_HALF_PLL : `RD_LAT_HALF_OFF;

        // strap caught once the synchroniser holds a settled level
        if (!s.init_done) begin
            if (s.init_cnt == 2'h3) begin
                next_s.init_done = 1'b1;
                next_s.term_high = s.sync_ctl[`IN_TERM]; // low range or high range
            end else begin
                next_s.init_cnt = s.init_cnt + 2'h1;
            end
        end

        // every half cycle moves the read pipe and the output stage
        if (k_rise || kn_rise) begin
            next_s.rd_pipe = {s.rd_pipe[PIPE-2:0], rd_new};
            next_s.rd_addr = {s.rd_addr[PIPE-2:0], s.sync_addr};
            // echo follows k at every edge, busy or idle
            next_s.echo = k_rise;
            next_s.echo_n = ~k_rise;
            if (next_s.rd_pipe[lat]) begin
                // first word of a burst
                next_s.dq_o = s.mem[next_s.rd_addr[lat]][0];
                next_s.dq_oe_n = 1'b0;
                next_s.valid = 1'b1; // flag changes with the echo edge
            end else if (next_s.rd_pipe[lat+1]) begin
                // second word, on the opposite clock
                next_s.dq_o = s.mem[next_s.rd_addr[lat+1]][1];
                next_s.dq_oe_n = 1'b0;
                next_s.valid = 1'b1;
            end else begin
                // nothing due: release the bus and drop the flag
                next_s.dq_oe_n = 1'b1;
                next_s.valid = 1'b0;
            end
        end

        // k rise: mode sample, first write word, new write command
        if (k_rise) begin
            next_s.pll_on = s.sync_ctl[`IN_PLL]; // low switches to one-cycle mode
            if (s.wr_cmd) begin
                // first word lands on the k rise after the command
                next_s.mem[s.wr_cmd_addr][0] = s.sync_dq;
                next_s.wr_w1 = 1'b1;
                next_s.wr_dat_addr = s.wr_cmd_addr;
            end
            // load low with select low is a write
            next_s.wr_cmd = ~s.sync_ctl[`IN_LD] & ~s.sync_ctl[`IN_RW];
            next_s.wr_cmd_addr = s.sync_addr;
        end

        // k_n rise: second write word of the burst
        if (kn_rise && s.wr_w1) begin
            next_s.mem[s.wr_dat_addr][1] = s.sync_dq;
            next_s.wr_w1 = 1'b0;
        end
    end

    // state register; bus released, echo complement high in reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s <= '0;
            s.dq_oe_n <= 1'b1;
            s.echo_n <= 1'b1;
            // sync stages start at the idle pin levels: no false k_n rise or load after reset
            s.meta_ctl[`IN_KN] <= 1'b1;
            s.sync_ctl[`IN_KN] <= 1'b1;
            s.kn_prev <= 1'b1;
            s.meta_ctl[`IN_LD] <= 1'b1;
            s.sync_ctl[`IN_LD] <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule : ddrb_sram_dev
